// ==== rtl/fp_error_defs.svh ====
// register offsets, field positions, reset values and constants of the fp error unit
`ifndef FP_ERROR_DEFS_SVH
`define FP_ERROR_DEFS_SVH

`define FPE_ADDR_W            8
`define FPE_OFF_CONTROL       8'h00
`define FPE_OFF_STATUS_WORD   8'h04
`define FPE_OFF_EXC_MASK      8'h08
`define FPE_OFF_FAULT_IP      8'h0C
`define FPE_OFF_IRQ_STATUS    8'h10
`define FPE_OFF_IRQ_MASK      8'h14
`define FPE_OFF_PIN_STATE     8'h18

`define FPE_NATIVE_BIT        5
`define FPE_FLAGS_W           6
`define FPE_SUMMARY_BIT       7
`define FPE_EVENTS_W          4

`define FPE_EV_UNMASKED       0
`define FPE_EV_PIN_RISE       1
`define FPE_EV_STALL          2
`define FPE_EV_VECTOR         3

`define FPE_PIN_ERROR_OUT     0
`define FPE_PIN_IGNORE        1
`define FPE_PIN_IRQ_REQUEST   2
`define FPE_PIN_STALL         3

`define FPE_CONTROL_RESET     32'h0000_0000
`define FPE_EXC_MASK_RESET    6'h3F
`define FPE_IRQ_MASK_RESET    4'h0
`define FPE_VECTOR_NUM        8'h10

`endif

// ==== rtl/fp_error_pkg.sv ====
// types shared by the fp error reporting unit and its bench
package fp_error_pkg;

  typedef enum logic [2:0] {
    KIND_OTHER      = 3'b000,
    KIND_WAIT       = 3'b001,
    KIND_FP_WAITING = 3'b010,
    KIND_FP_NOWAIT  = 3'b011,
    KIND_SIMD       = 3'b100
  } insn_kind_t;

  typedef enum logic [1:0] {
    PIN_IDLE     = 2'b00,
    PIN_DEFERRED = 2'b01,
    PIN_ASSERTED = 2'b10
  } pin_state_t;

  typedef struct packed {
    logic [5:0]  flags;
    logic        defer;
    logic [31:0] ip;
  } exc_report_t;

  typedef struct packed {
    logic        valid;
    insn_kind_t  kind;
  } insn_req_t;

endpackage : fp_error_pkg

// ==== rtl/fp_error_pin_reporting.sv ====
// fp error reporting unit: status word, error pin, instruction freeze, avalon register slave
`timescale 1ns/1ps
`include "fp_error_defs.svh"

// Functional notes
// RL1 - native select clear means reporting through error pin, request and ignore pins.
// RL2 - an unmasked exception sets its own flag and the summary flag.
// RL3 - with ignore low, error pin rises at once or before next waiting instruction.
// RL4 - pending unmasked exception freezes next wait, waiting fp or simd instruction.
// RL5 - outside logic routes error pin to interrupt controller line thirteen, vector 75H.
// RL6 - the interrupt controller raises the request input for vector 75H.
// RL7 - ignore high makes the unit disregard error conditions and raise nothing; the code does so only with native select clear.
// RL8 - faulting instruction pointer is kept for the handler to restart there.
// RL9 - native select set reports pending exceptions internally on vector 16.
// RL10 - non-waiting fp instructions run without stall even with an exception pending.
// RL11 - error pin stays high until software clears flags and summary, then drops.
module fp_error_pin_reporting (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic [`FPE_ADDR_W-1:0]     address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  input  wire logic [3:0]                 byteenable,
  output logic      [31:0]                readdata,
  output logic                            waitrequest,
  input  wire fp_error_pkg::exc_report_t  exc_report,
  input  wire logic                       exc_valid,
  input  wire fp_error_pkg::insn_req_t    insn_req,
  output logic                            insn_accept,
  output logic                            insn_stall,
  output logic                            fp_error_vector_take,
  output logic      [7:0]                 fp_error_vector,
  output logic                            fp_error_out,
  input  wire logic                       ignore_numeric_error_in,
  input  wire logic                       interrupt_request_in,
  output logic                            irq
);

  function automatic logic is_waiting(input fp_error_pkg::insn_kind_t kind);
    is_waiting = (kind == fp_error_pkg::KIND_WAIT) || (kind == fp_error_pkg::KIND_FP_WAITING) ||
                 (kind == fp_error_pkg::KIND_SIMD);
  endfunction : is_waiting

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? data[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  logic [31:0]                control_register_zero;
  logic [`FPE_FLAGS_W-1:0]    exc_flags;
  logic                       error_summary_flag;
  logic [`FPE_FLAGS_W-1:0]    exc_mask;
  logic [31:0]                fault_ip;
  logic [`FPE_EVENTS_W-1:0]   irq_status;
  logic [`FPE_EVENTS_W-1:0]   irq_mask;
  logic [`FPE_EVENTS_W-1:0]   events;
  logic                       vector_sent;
  fp_error_pkg::pin_state_t   pin_state;
  fp_error_pkg::pin_state_t   next_pin_state;
  logic [31:0]                next_readdata;

  logic native_report_select;
  logic wr_done;
  logic rd_done;
  logic sw_status_write;
  logic [31:0] status_merged;
  logic [`FPE_FLAGS_W-1:0] unmasked;
  logic raise;
  logic waiting_blocked;

  assign native_report_select = control_register_zero[`FPE_NATIVE_BIT];
  assign wr_done = write & ~waitrequest;
  assign rd_done = read & ~waitrequest;
  assign sw_status_write = wr_done && (address == `FPE_OFF_STATUS_WORD);
  assign status_merged = merge({24'h00_0000, error_summary_flag, 1'b0, exc_flags}, writedata, byteenable);
  assign unmasked = exc_report.flags & ~exc_mask;
  // ignore pin only matters in compatibility mode
  assign raise = exc_valid && (unmasked != '0) && (native_report_select || !ignore_numeric_error_in); // RL7
  assign waiting_blocked = insn_req.valid && is_waiting(insn_req.kind) && error_summary_flag;

  // avalon slave: one wait state on every access
  always_ff @(posedge clk) begin
    if (reset) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read | write) & waitrequest);
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    case (address)
      `FPE_OFF_CONTROL:     next_readdata = control_register_zero;
      `FPE_OFF_STATUS_WORD: next_readdata = {24'h00_0000, error_summary_flag, 1'b0, exc_flags};
      `FPE_OFF_EXC_MASK:    next_readdata = {26'h000_0000, exc_mask};
      `FPE_OFF_FAULT_IP:    next_readdata = fault_ip;
      `FPE_OFF_IRQ_STATUS:  next_readdata = {28'h000_0000, irq_status};
      `FPE_OFF_IRQ_MASK:    next_readdata = {28'h000_0000, irq_mask};
      `FPE_OFF_PIN_STATE:   next_readdata = {28'h000_0000, insn_stall, interrupt_request_in,
                                             ignore_numeric_error_in, fp_error_out};
      default:              next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      readdata <= 32'h0000_0000;
    end else if (read & waitrequest) begin
      readdata <= next_readdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      control_register_zero <= `FPE_CONTROL_RESET;
      exc_mask              <= `FPE_EXC_MASK_RESET;
      irq_mask              <= `FPE_IRQ_MASK_RESET;
    end else if (wr_done) begin
      if (address == `FPE_OFF_CONTROL) begin
        control_register_zero <= merge(control_register_zero, writedata, byteenable); // RL1
      end
      if (address == `FPE_OFF_EXC_MASK && byteenable[0]) begin
        exc_mask <= writedata[`FPE_FLAGS_W-1:0];
      end
      if (address == `FPE_OFF_IRQ_MASK && byteenable[0]) begin
        irq_mask <= writedata[`FPE_EVENTS_W-1:0];
      end
    end
  end

  // status word: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      exc_flags          <= '0;
      error_summary_flag <= 1'b0;
    end else begin
      if (sw_status_write) begin
        exc_flags          <= status_merged[`FPE_FLAGS_W-1:0] | (raise ? unmasked : '0);
        error_summary_flag <= status_merged[`FPE_SUMMARY_BIT] | raise;
      end else if (raise) begin
        exc_flags          <= exc_flags | unmasked; // RL2
        error_summary_flag <= 1'b1; // RL2
      end
    end
  end

  // first faulting pointer kept until the summary is cleared or a raise coincides with a status word write
  always_ff @(posedge clk) begin
    if (reset) begin
      fault_ip <= 32'h0000_0000;
    end else if (raise && (!error_summary_flag || sw_status_write)) begin
      fault_ip <= exc_report.ip; // RL8
    end
  end

  // error pin sequencing in compatibility mode
  always_comb begin
    next_pin_state = pin_state;
    case (pin_state)
      fp_error_pkg::PIN_IDLE: begin
        if (raise && !native_report_select) begin
          next_pin_state = exc_report.defer ? fp_error_pkg::PIN_DEFERRED : fp_error_pkg::PIN_ASSERTED; // RL3
        end
      end
      fp_error_pkg::PIN_DEFERRED: begin
        if (!error_summary_flag) begin
          next_pin_state = fp_error_pkg::PIN_IDLE;
        end else if (waiting_blocked && !ignore_numeric_error_in) begin
          next_pin_state = fp_error_pkg::PIN_ASSERTED; // RL3
        end
      end
      fp_error_pkg::PIN_ASSERTED: begin
        if (!error_summary_flag && !raise) begin
          next_pin_state = fp_error_pkg::PIN_IDLE; // RL11
        end
      end
      default: next_pin_state = fp_error_pkg::PIN_IDLE;
    endcase
    if (native_report_select) begin
      next_pin_state = fp_error_pkg::PIN_IDLE; // RL1
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_state    <= fp_error_pkg::PIN_IDLE;
      fp_error_out <= 1'b0;
    end else begin
      pin_state    <= next_pin_state;
      fp_error_out <= (next_pin_state == fp_error_pkg::PIN_ASSERTED); // RL11
    end
  end

  // instruction gate: waiting kinds freeze while summary set, others pass
  always_ff @(posedge clk) begin
    if (reset) begin
      insn_accept <= 1'b0;
      insn_stall  <= 1'b0;
    end else begin
      insn_accept <= insn_req.valid && !insn_accept && !waiting_blocked; // RL10
      insn_stall  <= waiting_blocked; // RL4
    end
  end

  // native vector: one pulse per pending summary, at the blocked instruction
  always_ff @(posedge clk) begin
    if (reset) begin
      fp_error_vector_take <= 1'b0;
      fp_error_vector      <= 8'h00;
      vector_sent          <= 1'b0;
    end else begin
      fp_error_vector_take <= 1'b0;
      if (!error_summary_flag) begin
        vector_sent <= 1'b0;
      end else if (native_report_select && waiting_blocked && !vector_sent) begin
        fp_error_vector_take <= 1'b1; // RL9
        fp_error_vector      <= `FPE_VECTOR_NUM; // RL9
        vector_sent          <= 1'b1;
      end
    end
  end

  assign events[`FPE_EV_UNMASKED] = raise;
  assign events[`FPE_EV_PIN_RISE] = (next_pin_state == fp_error_pkg::PIN_ASSERTED) && !fp_error_out;
  assign events[`FPE_EV_STALL]    = waiting_blocked && !insn_stall;
  assign events[`FPE_EV_VECTOR]   = native_report_select && waiting_blocked && !vector_sent;

  // sticky event bits, cleared by reading; a coincident event stays set
  for (genvar g = 0; g < `FPE_EVENTS_W; g++) begin : g_irq
    always_ff @(posedge clk) begin
      if (reset) begin
        irq_status[g] <= 1'b0;
      end else if (events[g]) begin
        irq_status[g] <= 1'b1;
      end else if (rd_done && address == `FPE_OFF_IRQ_STATUS) begin
        irq_status[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule : fp_error_pin_reporting

// ==== test/pic_glue_model.sv ====
// model of the glue logic and cascaded interrupt controller behind the error pin
`timescale 1ns/1ps
module pic_glue_model #(
  parameter int         DELAY  = 2,
  parameter logic [7:0] VECTOR = 8'h75
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       fp_error_out,
  output logic            interrupt_request_in,
  output logic      [7:0] vector
);
  logic [15:0] line;
  logic [3:0]  dly;
  // only input line thirteen is wired, the rest stay quiet
  assign line = {2'h0, fp_error_out, 13'h0000};
  // delay stands for controller latency; raise DELAY to answer slowly
  always_ff @(posedge clk) begin
    if (reset) dly <= 4'h0;
    else dly <= {dly[2:0], line[13]};
  end
  assign interrupt_request_in = dly[DELAY-1];
  assign vector = VECTOR;
endmodule : pic_glue_model

// ==== test/fp_error_pin_reporting_checker.sv ====
// port assertions for the fp error reporting unit
`timescale 1ns/1ps
module fp_error_pin_reporting_checker (
  input wire logic                    clk,
  input wire logic                    reset,
  input wire logic                    read,
  input wire logic                    write,
  input wire logic                    waitrequest,
  input wire logic                    exc_valid,
  input wire fp_error_pkg::insn_req_t insn_req,
  input wire logic                    insn_accept,
  input wire logic                    insn_stall,
  input wire logic                    fp_error_vector_take,
  input wire logic [7:0]              fp_error_vector,
  input wire logic                    fp_error_out,
  input wire logic                    ignore_numeric_error_in
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wait_low_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered in one cycle");
  wait_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  rise_cause_a: assert property ($rose(fp_error_out) |->
    $past(exc_valid) || $past(exc_valid, 2) || $past(insn_req.valid))
    else $error("error pin rose without a cause");
  // ignore held three samples so a report already in flight is not blamed
  ignore_hold_a: assert property (ignore_numeric_error_in && $past(ignore_numeric_error_in) &&
    $past(ignore_numeric_error_in, 2) && !fp_error_out |=> !fp_error_out)
    else $error("error pin rose while ignore was high");
  stall_block_a: assert property (insn_stall |-> !insn_accept)
    else $error("instruction accepted while frozen");
  stall_release_a: assert property ($fell(insn_stall) |->
    $past(write) || $past(write, 2) || $past(write, 3) || $past(reset))
    else $error("freeze ended without a clearing write");
  nowait_pass_a: assert property (insn_req.valid && insn_req.kind == fp_error_pkg::KIND_FP_NOWAIT &&
    !insn_accept |=> insn_accept)
    else $error("non-waiting instruction not accepted next cycle");
  accept_pulse_a: assert property (insn_accept |=> !insn_accept)
    else $error("accept high on two cycles");
  vector_num_a: assert property (fp_error_vector_take |-> fp_error_vector == 8'h10)
    else $error("wrong internal vector number");
  pin_hold_a: assert property ($fell(fp_error_out) |->
    $past(write) || $past(write, 2) || $past(reset))
    else $error("error pin dropped without a clearing write");
  cover property ($rose(insn_stall));
  cover property ($rose(fp_error_out));
  cover property (fp_error_vector_take);
endmodule : fp_error_pin_reporting_checker

bind fp_error_pin_reporting fp_error_pin_reporting_checker chk_i (.clk, .reset, .read, .write, .waitrequest,
  .exc_valid, .insn_req, .insn_accept, .insn_stall, .fp_error_vector_take, .fp_error_vector, .fp_error_out,
  .ignore_numeric_error_in);

// ==== test/fp_error_pin_reporting_tb.sv ====
// bench: register, exception and instruction scenarios for the fp error unit
`timescale 1ns/1ps
`include "fp_error_defs.svh"
module fp_error_pin_reporting_tb;
  logic                      clk, reset, read, write, waitrequest, exc_valid, insn_accept, insn_stall, got;
  logic                      fp_error_vector_take, fp_error_out, ignore_numeric_error_in, interrupt_request_in, irq;
  logic [7:0]                address, fp_error_vector;
  logic [31:0]               writedata, readdata, q;
  logic [3:0]                byteenable;
  fp_error_pkg::exc_report_t exc_report;
  fp_error_pkg::insn_req_t   insn_req;
  fp_error_pkg::insn_kind_t  wk [3];
  int                        fails, checked, cycles;
  fp_error_pin_reporting DUT (.clk, .reset, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .exc_report, .exc_valid, .insn_req, .insn_accept, .insn_stall, .fp_error_vector_take,
    .fp_error_vector, .fp_error_out, .ignore_numeric_error_in, .interrupt_request_in, .irq);
  pic_glue_model #(.DELAY(2)) glue (.clk, .reset, .fp_error_out, .interrupt_request_in, .vector());
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      $display("[ERR] cycles expected below %0d seen %0d", 3000, cycles);
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= ~w;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : acc
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), e, q);
  endtask : rc
  task automatic exc(input logic [5:0] f, input logic df);
    @(posedge clk);
    exc_report <= '{f, df, 32'h0000_1230 + f};
    exc_valid <= 1'b1;
    @(posedge clk);
    exc_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : exc
  // also captures the internal vector, since its strobe is a single pulse
  task automatic aw(input int lim);
    got = 1'b0;
    q = 32'h0000_0000;
    repeat (lim) begin
      @(posedge clk);
      if (fp_error_vector_take === 1'b1) q = {24'h00_0000, fp_error_vector};
      if (insn_accept === 1'b1 && !got) begin
        got = 1'b1;
        insn_req <= '0;
      end
    end
  endtask : aw
  initial begin
    reset = 1'b1;
    {read, write, exc_valid, ignore_numeric_error_in} = 4'h0;
    address = 8'h00;
    writedata = 32'h0000_0000;
    byteenable = 4'hF;
    exc_report = '0;
    insn_req = '0;
    wk = '{fp_error_pkg::KIND_WAIT, fp_error_pkg::KIND_FP_WAITING, fp_error_pkg::KIND_SIMD};
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rc(`FPE_OFF_CONTROL, 32'h0000_0000);
    rc(`FPE_OFF_EXC_MASK, 32'h0000_003F);
    rc(`FPE_OFF_IRQ_MASK, 32'h0000_0000);
    rc(8'h1C, 32'h0000_0000);
    acc(1'b1, `FPE_OFF_EXC_MASK, 32'h0000_0000);
    acc(1'b1, `FPE_OFF_IRQ_MASK, 32'h0000_000F);
    $display("test registers done");
    exc(6'h04, 1'b0);
    chk("error pin", 1, fp_error_out);
    exc(6'h01, 1'b0);
    rc(`FPE_OFF_STATUS_WORD, 32'h0000_0085);
    rc(`FPE_OFF_FAULT_IP, 32'h0000_1234);
    rc(`FPE_OFF_PIN_STATE, 32'h0000_0005);
    chk("irq", 1, irq);
    rc(`FPE_OFF_IRQ_STATUS, 32'h0000_0003);
    rc(`FPE_OFF_IRQ_STATUS, 32'h0000_0000);
    insn_req <= '{1'b1, fp_error_pkg::KIND_FP_NOWAIT};
    aw(3);
    chk("nowait accept", 1, got);
    chk("irq", 0, irq);
    acc(1'b1, `FPE_OFF_STATUS_WORD, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk("pin clear", 0, fp_error_out);
    $display("test immediate done");
    foreach (wk[i]) begin
      exc(6'h02, 1'b1);
      chk("deferred pin", 0, fp_error_out);
      insn_req <= '{1'b1, wk[i]};
      aw(4);
      chk("frozen", 0, got);
      chk("stall", 1, insn_stall);
      chk("late pin", 1, fp_error_out);
      acc(1'b1, `FPE_OFF_STATUS_WORD, 32'h0000_0000);
      aw(6);
      chk("released", 1, got);
      chk("pin clear", 0, fp_error_out);
    end
    $display("test deferred done");
    ignore_numeric_error_in <= 1'b1;
    exc(6'h08, 1'b0);
    chk("ignored pin", 0, fp_error_out);
    rc(`FPE_OFF_STATUS_WORD, 32'h0000_0000);
    ignore_numeric_error_in <= 1'b0;
    $display("test ignore done");
    acc(1'b1, `FPE_OFF_CONTROL, 32'h0000_0020);
    exc(6'h10, 1'b0);
    chk("native pin", 0, fp_error_out);
    insn_req <= '{1'b1, fp_error_pkg::KIND_FP_WAITING};
    aw(4);
    chk("vector", 32'h0000_0010, q);
    chk("native stall", 1, insn_stall);
    acc(1'b1, `FPE_OFF_STATUS_WORD, 32'h0000_0000);
    aw(6);
    chk("native released", 1, got);
    chk("native unstall", 0, insn_stall);
    rc(`FPE_OFF_IRQ_STATUS, 32'h0000_000F);
    $display("test native done");
    give_verdict();
  end
endmodule : fp_error_pin_reporting_tb
